/* rtl/image_pipe_defines.svh */
// Register offsets, field positions and reset values of the frame start control
`ifndef IMAGE_PIPE_DEFINES_SVH
`define IMAGE_PIPE_DEFINES_SVH
// Byte offsets on the register bus
`define OFS_RUN 12'h000
`define OFS_MODE 12'h004
`define OFS_PATH 12'h008
`define OFS_VSTART 12'h010
`define OFS_VSIZE 12'h014
`define OFS_HSTART 12'h018
`define OFS_HSIZE 12'h01C
`define OFS_STATUS 12'h020
`define ADDR_WORD_MASK 12'hFFC
// Field positions
`define RUN_BIT 0
`define SINGLE_BIT 0
`define WRT_BIT 1
`define PATH_MSB 1
`define PATH_LSB 0
`define POS_MSB 15
`define SIZE_MSB 12
`define STAT_WAIT_BIT 0
`define STAT_BUSY_BIT 1
`define BYTE_W 8
`define BYTE_LANES 4
// Reset values
`define RST_FLAG 1'b0
`define RST_POS 16'h0000
`define RST_SIZE 13'h0000
`define RST_HSIZE 13'h0001
`define RST_PIXEL 16'h0000
`define HSIZE_LSB_FIXED 1'b1
// Counter helpers
`define CNT_ONE 17'h0_0001
`define CNT_MAX 17'h1_FFFF
`endif

/* rtl/image_pipe_pkg.sv */
// Types shared by the frame start control and its area tracker
package image_pipe_pkg;
   typedef logic [31:0] word_t;
   typedef logic [11:0] addr_t;
   typedef logic [15:0] pos_t;
   typedef logic [12:0] size_t;
   typedef logic [15:0] pixel_t;
   typedef logic [16:0] cnt_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARMED = 2'b01,
      ST_RUN = 2'b10
   } state_e;
   typedef enum logic [1:0] {
      PATH_RAW_TO_YCC = 2'b00,
      PATH_RAW_TO_RAW = 2'b01,
      PATH_RAW_NO_OUT = 2'b10,
      PATH_YCC_TO_YCC = 2'b11
   } path_e;
   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_RUN = 3'b001,
      SEL_MODE = 3'b010,
      SEL_PATH = 3'b011,
      SEL_VSTART = 3'b100,
      SEL_VSIZE = 3'b101,
      SEL_HSTART = 3'b110,
      SEL_HSIZE = 3'b111
   } reg_sel_e;
endpackage

/* rtl/frame_area_tracker.sv */
// Processing-area tracker: line and pixel position inside one frame
`timescale 1ns/100ps
`include "image_pipe_defines.svh"
module frame_area_tracker (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic start,
   input wire logic lineRise,
   input wire logic strobe,
   input wire image_pipe_pkg::pos_t vStart,
   input wire image_pipe_pkg::size_t vSize,
   input wire image_pipe_pkg::pos_t hStart,
   input wire image_pipe_pkg::size_t hSize,
   output logic inArea,
   output logic areaEnd
);
   import image_pipe_pkg::*;

   logic active_q, active_d;
   cnt_t line_q, line_d;
   cnt_t pix_q, pix_d;
   cnt_t vEnd, hEnd;

   // End positions are inclusive, so size VAL covers VAL+1 lines or pixels
   always_comb begin
      vEnd = cnt_t'(vStart) + cnt_t'(vSize);
      hEnd = cnt_t'(hStart) + cnt_t'(hSize);
      inArea = active_q && (line_q >= cnt_t'(vStart)) && (line_q <= vEnd) &&
               (pix_q >= cnt_t'(hStart)) && (pix_q <= hEnd);
      areaEnd = inArea && strobe && (line_q == vEnd) && (pix_q == hEnd);
   end

   // Counters saturate so a missing frame end never wraps into the area again
   always_comb begin
      active_d = active_q;
      line_d = line_q;
      pix_d = pix_q;
      if (start) begin
         active_d = 1'b1;
         line_d = '0;
         pix_d = '0;
      end else if (active_q) begin
         if (areaEnd) begin
            active_d = 1'b0;
         end
         if (lineRise) begin
            pix_d = '0;
            if (line_q != `CNT_MAX) begin
               line_d = line_q + `CNT_ONE;
            end
         end else if (strobe && (pix_q != `CNT_MAX)) begin
            pix_d = pix_q + `CNT_ONE;
         end
      end
   end

   // Position registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         active_q <= 1'b0;
         line_q <= '0;
         pix_q <= '0;
      end else begin
         active_q <= active_d;
         line_q <= line_d;
         pix_q <= pix_d;
      end
   end
endmodule // frame_area_tracker

/* rtl/image_pipe_frame_start_control.sv */
// Frame start control: register bank, vertical-sync arming and pixel gating
// Summary of operation
// - Run flag starts processing at next vertical sync
// - Single-frame mode clears run flag at area end
// - Mode bit 0: free-running or single-frame
// - Mode bit 1: ignore or honour write-valid
// - Run flag resets to zero, read/write bit 0
// - Two-bit field selects the input/output data path
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`include "image_pipe_defines.svh"
module image_pipe_frame_start_control (
   input wire logic ref_clk,
   input wire logic srst,
   input wire image_pipe_pkg::addr_t address,
   input wire logic read,
   input wire logic write,
   input wire image_pipe_pkg::word_t writedata,
   input wire logic [3:0] byteenable,
   output image_pipe_pkg::word_t readdata,
   output logic waitrequest,
   input wire logic vertSync,
   input wire logic horizSync,
   input wire logic writeValid,
   input wire image_pipe_pkg::pixel_t pixelIn,
   output image_pipe_pkg::pixel_t pixelOut,
   output logic pixelOutValid,
   output image_pipe_pkg::path_e pathSel,
   output logic frameBusy,
   output logic frameDone
);
   import image_pipe_pkg::*;

   // Bus handshake state
   logic ack_q, ack_d;
   word_t rdata_q, rdata_d;
   // Software-visible registers
   logic run_q, run_d;
   logic single_q, single_d;
   logic useWrt_q, useWrt_d;
   path_e path_q, path_d;
   pos_t vStart_q, vStart_d;
   size_t vSize_q, vSize_d;
   pos_t hStart_q, hStart_d;
   size_t hSize_q, hSize_d;
   // Frame sequencing state
   state_e state_q, state_d;
   logic vsPrev_q, hsPrev_q;
   pixel_t pixOut_q, pixOut_d;
   logic pixValid_q, pixValid_d;
   logic done_q, done_d;
   // Combinational helpers
   reg_sel_e sel;
   logic isStatus;
   word_t regWord, newWord;
   logic busReq, wrEn;
   logic vsRise, hsRise, strobe, trkStart, trkInArea, trkDone;

   // Word-aligned address decode; the low two address bits are ignored
   function automatic reg_sel_e decodeAddr(input addr_t a);
      reg_sel_e s;
      s = SEL_NONE;
      case (a & `ADDR_WORD_MASK)
         `OFS_RUN: s = SEL_RUN;
         `OFS_MODE: s = SEL_MODE;
         `OFS_PATH: s = SEL_PATH;
         `OFS_VSTART: s = SEL_VSTART;
         `OFS_VSIZE: s = SEL_VSIZE;
         `OFS_HSTART: s = SEL_HSTART;
         `OFS_HSIZE: s = SEL_HSIZE;
         default: s = SEL_NONE;
      endcase
      return s;
   endfunction

   // Byte-enable merge of write data over the current register word
   function automatic word_t mergeLanes(input word_t old, input word_t wd,
                                        input logic [3:0] be);
      word_t m;
      m = '0;
      for (int i = 0; i < `BYTE_LANES; i++) begin
         m[i*`BYTE_W +: `BYTE_W] = {`BYTE_W{be[i]}};
      end
      return (old & ~m) | (wd & m);
   endfunction

   // Only the no-output path suppresses the pixel stream
   function automatic logic pathHasOutput(input path_e p);
      return (p != PATH_RAW_NO_OUT);
   endfunction

   // Read mux; reserved bits come back as zero because they are never stored
   always_comb begin
      sel = decodeAddr(address);
      isStatus = ((address & `ADDR_WORD_MASK) == `OFS_STATUS);
      regWord = '0;
      case (sel)
         SEL_RUN: regWord[`RUN_BIT] = run_q;
         SEL_MODE: begin
            regWord[`SINGLE_BIT] = single_q;
            regWord[`WRT_BIT] = useWrt_q;
         end
         SEL_PATH: regWord[`PATH_MSB:`PATH_LSB] = path_q;
         SEL_VSTART: regWord[`POS_MSB:0] = vStart_q;
         SEL_VSIZE: regWord[`SIZE_MSB:0] = vSize_q;
         SEL_HSTART: regWord[`POS_MSB:0] = hStart_q;
         SEL_HSIZE: regWord[`SIZE_MSB:0] = hSize_q;
         default: begin
            if (isStatus) begin
               regWord[`STAT_WAIT_BIT] = (state_q == ST_ARMED);
               regWord[`STAT_BUSY_BIT] = (state_q == ST_RUN);
            end
         end
      endcase
      newWord = mergeLanes(regWord, writedata, byteenable);
   end

   // Every access waits exactly one cycle; read data is captured on entry
   always_comb begin
      busReq = (read | write) & ~ack_q;
      ack_d = busReq;
      rdata_d = rdata_q;
      if (busReq) begin
         rdata_d = read ? regWord : '0;
      end
      wrEn = write & ack_q;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ack_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   assign waitrequest = (read | write) & ~ack_q;
   assign readdata = rdata_q;

   // Register updates; a software write of the run flag beats the
   // hardware clear so a re-arm issued at frame end is never dropped
   always_comb begin
      run_d = run_q;
      single_d = single_q;
      useWrt_d = useWrt_q;
      path_d = path_q;
      vStart_d = vStart_q;
      vSize_d = vSize_q;
      hStart_d = hStart_q;
      hSize_d = hSize_q;
      if ((state_q == ST_RUN) && trkDone && single_q) begin
         run_d = 1'b0;
      end
      if (wrEn) begin
         case (sel)
            SEL_RUN: run_d = newWord[`RUN_BIT];
            SEL_MODE: begin
               single_d = newWord[`SINGLE_BIT];
               useWrt_d = newWord[`WRT_BIT];
            end
            SEL_PATH: path_d = path_e'(newWord[`PATH_MSB:`PATH_LSB]);
            SEL_VSTART: vStart_d = newWord[`POS_MSB:0];
            SEL_VSIZE: vSize_d = newWord[`SIZE_MSB:0];
            SEL_HSTART: hStart_d = newWord[`POS_MSB:0];
            // The size LSB is fixed so the line width stays even
            SEL_HSIZE: hSize_d = {newWord[`SIZE_MSB:1], `HSIZE_LSB_FIXED};
            default: run_d = run_d; // Unmapped writes are dropped
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         run_q <= `RST_FLAG;
         single_q <= `RST_FLAG;
         useWrt_q <= `RST_FLAG;
         path_q <= PATH_RAW_TO_YCC;
         vStart_q <= `RST_POS;
         vSize_q <= `RST_SIZE;
         hStart_q <= `RST_POS;
         hSize_q <= `RST_HSIZE;
      end else begin
         run_q <= run_d;
         single_q <= single_d;
         useWrt_q <= useWrt_d;
         path_q <= path_d;
         vStart_q <= vStart_d;
         vSize_q <= vSize_d;
         hStart_q <= hStart_d;
         hSize_q <= hSize_d;
      end
   end

   // Sync edges and data qualification
   always_comb begin
      vsRise = vertSync & ~vsPrev_q;
      hsRise = horizSync & ~hsPrev_q;
      strobe = useWrt_q ? writeValid : 1'b1;
      trkStart = vsRise & run_q & (state_q != ST_IDLE);
   end

   frame_area_tracker u_tracker (
      .ref_clk(ref_clk),
      .srst(srst),
      .start(trkStart),
      .lineRise(hsRise),
      .strobe(strobe),
      .vStart(vStart_q),
      .vSize(vSize_q),
      .hStart(hStart_q),
      .hSize(hSize_q),
      .inArea(trkInArea),
      .areaEnd(trkDone)
   );

   // Frame sequencing: a set run flag only arms; the frame waits for sync
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (run_q) begin
               state_d = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (!run_q) begin
               state_d = ST_IDLE;
            end else if (vsRise) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (vsRise) begin
               state_d = run_q ? ST_RUN : ST_IDLE;
            end else if (trkDone) begin
               state_d = (run_q && !single_q) ? ST_ARMED : ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      pixValid_d = (state_q == ST_RUN) && trkInArea && strobe &&
                   pathHasOutput(path_q);
      pixOut_d = pixValid_d ? pixelIn : pixOut_q;
      done_d = (state_q == ST_RUN) && trkDone && !vsRise;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_q <= ST_IDLE;
         vsPrev_q <= 1'b0;
         hsPrev_q <= 1'b0;
         pixOut_q <= `RST_PIXEL;
         pixValid_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         vsPrev_q <= vertSync;
         hsPrev_q <= horizSync;
         pixOut_q <= pixOut_d;
         pixValid_q <= pixValid_d;
         done_q <= done_d;
      end
   end

   assign pixelOut = pixOut_q;
   assign pixelOutValid = pixValid_q;
   assign pathSel = path_q;
   assign frameBusy = (state_q == ST_RUN);
   assign frameDone = done_q;

   // Checks on the sequencing and the register bank
   logic runWrite;
   assign runWrite = wrEn && (sel == SEL_RUN);

   sequence armedSync;
      (state_q == ST_ARMED) && run_q && vsRise;
   endsequence

   sequence frameEndNoWrite;
      (state_q == ST_RUN) && trkDone && !vsRise && !runWrite;
   endsequence

   start_on_sync_a: assert property (@(posedge ref_clk) disable iff (srst)
      armedSync |=> frameBusy ##1 frameBusy || frameDone || !run_q || vsRise)
      else $error("frame did not start on the vertical sync edge");

   no_early_start_a: assert property (@(posedge ref_clk) disable iff (srst)
      (state_q != ST_RUN) && !vsRise |=> !frameBusy)
      else $error("frame started without a vertical sync edge");

   single_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
      frameEndNoWrite ##0 single_q |=> !run_q && (state_q == ST_IDLE) && frameDone)
      else $error("single-frame end did not clear the run flag");

   free_rearm_a: assert property (@(posedge ref_clk) disable iff (srst)
      frameEndNoWrite ##0 (!single_q && run_q) |=> run_q && (state_q == ST_ARMED))
      else $error("free-running frame end did not rearm");

   run_reset_a: assert property (@(posedge ref_clk)
      srst |=> !run_q && !pixelOutValid && (state_q == ST_IDLE))
      else $error("run flag or output not cleared by reset");

   strobe_ignored_a: assert property (@(posedge ref_clk) disable iff (srst)
      frameBusy && trkInArea && !useWrt_q && pathHasOutput(path_q)
      |=> pixelOutValid && (pixelOut == $past(pixelIn)))
      else $error("pixel dropped while write-valid is ignored");

   strobe_used_a: assert property (@(posedge ref_clk) disable iff (srst)
      useWrt_q && !writeValid |=> !pixelOutValid)
      else $error("pixel passed without write-valid");

   path_disable_a: assert property (@(posedge ref_clk) disable iff (srst)
      (path_q == PATH_RAW_NO_OUT) |=> !pixelOutValid && $stable(pixelOut))
      else $error("output active on the disabled data path");

   reserved_zero_a: assert property (@(posedge ref_clk) disable iff (srst)
      read && !waitrequest && (sel == SEL_MODE) |-> (readdata[31:2] == '0))
      else $error("reserved mode bits read nonzero");

   bus_answer_a: assert property (@(posedge ref_clk) disable iff (srst)
      (read || write) && waitrequest |=> !waitrequest ##1 !ack_q)
      else $error("bus access not answered after one wait cycle");
endmodule // image_pipe_frame_start_control

/* tb/pixel_source.sv */
// Upstream pixel source model: syncs, write-valid and a running pixel pattern
`timescale 1ns/100ps
module pixel_source (
   input wire logic ref_clk,
   input wire logic [1:0] wvMode,
   output logic vertSync,
   output logic horizSync,
   output logic writeValid,
   output image_pipe_pkg::pixel_t pixelIn
);
   import image_pipe_pkg::*;

   // Idle levels at time zero
   initial begin
      vertSync = 1'b0;
      horizSync = 1'b0;
      writeValid = 1'b0;
      pixelIn = 16'h0000;
   end

   // Data ticks every cycle so a stale value never looks like a held pixel
   always @(posedge ref_clk) begin
      pixelIn <= pixelIn + 16'h0001;
      writeValid <= (wvMode == 2'h1) ? ~writeValid : (wvMode == 2'h0); // 0 high, 1 toggle, 2 low
   end

   // One frame: vertical sync pulse, a short line 0, then lines led by horizontal sync
   task automatic frame(input int nLines, input int len);
      @(posedge ref_clk);
      vertSync <= 1'b1;
      repeat (2) @(posedge ref_clk);
      vertSync <= 1'b0;
      repeat (3) @(posedge ref_clk);
      for (int l = 0; l < nLines; l++) begin
         horizSync <= 1'b1;
         @(posedge ref_clk);
         horizSync <= 1'b0;
         repeat (len) @(posedge ref_clk);
      end
      repeat (4) @(posedge ref_clk);
   endtask
endmodule // pixel_source

/* tb/tb.sv */
// Register and frame-start testbench for the frame start control
`timescale 1ns/100ps
`include "image_pipe_defines.svh"
module tb;
   import image_pipe_pkg::*;
   localparam int VSZ = 1;
   localparam int HST = 2;
   localparam int HSZ = 3;
   localparam int EXP = (VSZ + 1) * (HSZ + 1);
   logic ref_clk;
   logic srst;
   logic read;
   logic write;
   addr_t address;
   word_t writedata;
   word_t readdata;
   word_t rd;
   logic [3:0] byteenable;
   logic waitrequest;
   logic vertSync;
   logic horizSync;
   logic writeValid;
   pixel_t pixelIn;
   pixel_t pixPrev;
   pixel_t pixelOut;
   logic pixelOutValid;
   path_e pathSel;
   logic frameBusy;
   logic frameDone;
   logic [1:0] wvMode;
   logic wvCheck;
   logic wvPrev;
   int mismatches;
   int cmp_count;
   int pixCount;
   int doneCount;
   int badWv;

   image_pipe_frame_start_control DUT (
      .ref_clk(ref_clk), .srst(srst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .vertSync(vertSync), .horizSync(horizSync),
      .writeValid(writeValid), .pixelIn(pixelIn), .pixelOut(pixelOut),
      .pixelOutValid(pixelOutValid), .pathSel(pathSel), .frameBusy(frameBusy),
      .frameDone(frameDone)
   );

   pixel_source src (
      .ref_clk(ref_clk), .wvMode(wvMode), .vertSync(vertSync), .horizSync(horizSync),
      .writeValid(writeValid), .pixelIn(pixelIn)
   );

   // 40 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Avalon access: request held until waitrequest is sampled low
   task automatic bus_access(input logic wr, input addr_t a, input word_t d,
         input logic [3:0] be, output word_t q);
      int n;
      n = 0;
      @(posedge ref_clk);
      read <= ~wr;
      write <= wr;
      address <= a;
      writedata <= d;
      byteenable <= be;
      do begin
         @(posedge ref_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) mismatches++;
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input addr_t a, input word_t d);
      bus_access(1'b1, a, d, 4'hF, rd);
   endtask

   task automatic rdchk(input string name, input addr_t a, input word_t exp);
      bus_access(1'b0, a, 32'h0000_0000, 4'hF, rd);
      check(name, rd, exp);
   endtask

   // Counts passed pixels and done pulses; a gated pixel needs write-valid one cycle before
   always @(posedge ref_clk) begin
      if (pixelOutValid === 1'b1) pixCount++;
      if (frameDone === 1'b1) doneCount++;
      if (pixelOutValid === 1'b1 && wvCheck && wvPrev !== 1'b1) badWv++;
      // A passed pixel carries the source value of the cycle before it
      if (pixelOutValid === 1'b1) check("pixel data", pixelOut, pixPrev);
      wvPrev = writeValid;
      pixPrev = pixelIn;
   end

   // One frame of four lines; only lines 1 and 2, pixels 2 to 5, lie in the area
   task automatic frame_check(input int exp, input int expDone);
      pixCount = 0;
      doneCount = 0;
      badWv = 0;
      src.frame(4, 16);
      check("pixels", pixCount, exp);
      if (expDone >= 0) check("done", doneCount, expDone);
      check("wv gate", badWv, 0);
   endtask

   // Hang guard well beyond the fewer than one thousand cycles the tests need
   initial begin
      #(25 * 20000);
      mismatches++;
      stop_test();
   end

   // Main sequence
   initial begin
      srst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 12'h000;
      writedata = 32'h0000_0000;
      byteenable = 4'hF;
      wvMode = 2'h0;
      wvCheck = 1'b0;
      wvPrev = 1'b0;
      pixPrev = 16'h0000;
      mismatches = 0;
      cmp_count = 0;
      pixCount = 0;
      doneCount = 0;
      badWv = 0;
      repeat (20) @(posedge ref_clk);
      srst <= 1'b0;
      // Reset values and an unmapped place
      rdchk("run reset", `OFS_RUN, 32'h0000_0000);
      rdchk("mode reset", `OFS_MODE, 32'h0000_0000);
      rdchk("path reset", `OFS_PATH, 32'h0000_0000);
      rdchk("hsize reset", `OFS_HSIZE, 32'h0000_0001);
      rdchk("unmapped", 12'h00C, 32'h0000_0000);
      // Ones written to reserved places read back as zero
      wr(`OFS_MODE, 32'hFFFF_FFFF);
      rdchk("mode reserved", `OFS_MODE, 32'h0000_0003);
      wr(`OFS_PATH, 32'hFFFF_FFFC);
      rdchk("path reserved", `OFS_PATH, 32'h0000_0000);
      // Masked lanes leave the register untouched
      bus_access(1'b1, `OFS_MODE, 32'h0000_0000, 4'h0, rd);
      rdchk("mode masked", `OFS_MODE, 32'h0000_0003);
      // Every path code reaches the read-back and the path output
      for (int p = 0; p < 4; p++) begin
         wr(`OFS_PATH, word_t'(p));
         rdchk("path read", `OFS_PATH, word_t'(p));
         check("path out", {30'h0, pathSel}, word_t'(p));
      end
      // Processing area and free-running mode; reserved bits kept zero from here
      wr(`OFS_PATH, 32'h0000_0000);
      wr(`OFS_VSTART, 32'h0000_0001);
      wr(`OFS_VSIZE, word_t'(VSZ));
      wr(`OFS_HSTART, word_t'(HST));
      wr(`OFS_HSIZE, word_t'(HSZ));
      rdchk("hsize", `OFS_HSIZE, word_t'(HSZ));
      wr(`OFS_MODE, 32'h0000_0000);
      // Arming waits for the vertical sync, no pixels flowing meanwhile
      wr(`OFS_RUN, 32'h0000_0001);
      repeat (20) @(posedge ref_clk);
      check("busy before sync", frameBusy, 32'h0000_0000);
      check("idle pixels", pixCount, 32'h0000_0000);
      rdchk("armed", `OFS_STATUS, 32'h0000_0001);
      frame_check(EXP, 1);
      rdchk("run kept", `OFS_RUN, 32'h0000_0001);
      frame_check(EXP, 1);
      // Write-valid honoured: toggling, then held low
      wvMode <= 2'h1;
      wvCheck = 1'b1;
      wr(`OFS_MODE, 32'h0000_0002);
      frame_check(EXP, 1);
      wvMode <= 2'h2;
      frame_check(0, 0);
      // Write-valid ignored while low
      wr(`OFS_MODE, 32'h0000_0000);
      wvCheck = 1'b0;
      frame_check(EXP, 1);
      // Luma/chroma path passes pixels; the disabled path drops them but still ends the frame
      wr(`OFS_PATH, 32'h0000_0003);
      frame_check(EXP, 1);
      wr(`OFS_PATH, 32'h0000_0002);
      frame_check(0, 1);
      wr(`OFS_PATH, 32'h0000_0000);
      // Single frame: one frame, then the run flag is cleared by hardware
      wvMode <= 2'h0;
      wr(`OFS_MODE, 32'h0000_0001);
      frame_check(EXP, 1);
      rdchk("run cleared", `OFS_RUN, 32'h0000_0000);
      frame_check(0, 0);
      // A reset in the cycle after the run write, before any sync, clears a freshly set run flag
      wr(`OFS_RUN, 32'h0000_0001);
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      rdchk("run after reset", `OFS_RUN, 32'h0000_0000);
      rdchk("status after reset", `OFS_STATUS, 32'h0000_0000);
      stop_test();
   end
endmodule // tb
